/* rtl/kli_top.sv */
/*
 * Keyboard level interrupt unit: level select, line enable and hit flag
 * registers on the special function register port, the combined keyboard
 * request and the wake request for idle and power-down.
 * Assumes a one-cycle sfr_rd or sfr_wr strobe with sfr_addr valid in that
 * cycle, and that the global keyboard enable comes from logic on sys_clk.
 * Assumes the port one pins are pulled up and asynchronous to sys_clk, and
 * that the port logic reads key_line_enable to hand a line to the keyboard.
 * Assumes sys_clk keeps running while the core idles or powers down, since
 * the wake request is a registered level.
 * Assumes software services every flag that one read returns: the read
 * clears them all, and a released key leaves no trace afterwards.
 */
`timescale 1ns/1ps
// Function
// - eight inputs, each with programmable level interrupt
// - port one alternate function, wakes idle/power-down
// - eight sources share one interrupt request
// - global enable bit gates combined request
// - select bit 0 low, 1 high
// - flag sets when line shows selected level
// - flag reaches request only if enabled
// - disabled line is plain I/O, no interrupt
// - flags read only, read clears all
// - all three registers reset to zero
// - any subset of lines usable independently
module kli_top (
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic [7:0] sfr_addr,
   input  wire logic       sfr_wr,
   input  wire logic       sfr_rd,
   input  wire logic [7:0] sfr_wdata,
   output logic      [7:0] sfr_rdata,
   output logic            sfr_ack,
   input  wire logic [7:0] port_one_pins,
   input  wire logic       keypad_global_irq_enable,
   output logic      [7:0] key_line_enable,
   output logic            key_irq,
   output logic            wake_req
);
   import kli_pkg::*;

   // the whole register state is one word, registered by one process
   kli_state_t st_ff;
   kli_state_t nxt_st;

   // carries the selected levels out and the per-line hits back
   kli_line_if lines ();

   // one-hot register select; one decode serves both strobes
   typedef enum logic [3:0] {
      KLI_SEL_NONE  = 4'b0001,
      KLI_SEL_LEVEL = 4'b0010,
      KLI_SEL_ENBL  = 4'b0100,
      KLI_SEL_FLAGS = 4'b1000
   } kli_reg_sel_t;

   function automatic kli_reg_sel_t reg_decode(input logic [7:0] addr);
      kli_reg_sel_t sel;
      sel = KLI_SEL_NONE;
      case (addr)
         KLI_ADDR_LEVEL_SEL: begin
            sel = KLI_SEL_LEVEL;
         end
         KLI_ADDR_LINE_EN: begin
            sel = KLI_SEL_ENBL;
         end
         KLI_ADDR_HIT_FLAGS: begin
            sel = KLI_SEL_FLAGS;
         end
         default: begin
            sel = KLI_SEL_NONE;
         end
      endcase
      return sel;
   endfunction : reg_decode

   // the three registers are the only mapped addresses
   function automatic logic is_mapped(input kli_reg_sel_t sel);
      return sel != KLI_SEL_NONE;
   endfunction : is_mapped

   // the flag register is read only, so writes to it and to holes vanish
   function automatic kli_state_t write_reg(input kli_state_t   st,
                                            input kli_reg_sel_t sel,
                                            input logic [7:0]   wdata);
      kli_state_t nxt;
      nxt = st;
      case (sel)
         KLI_SEL_LEVEL: begin
            nxt.key_level_select = wdata;
         end
         KLI_SEL_ENBL: begin
            nxt.key_line_enable = wdata;
         end
         default: begin
            nxt = st;
         end
      endcase
      return nxt;
   endfunction : write_reg

   // read data; an unmapped address keeps the word last read
   function automatic logic [7:0] read_word(input kli_reg_sel_t sel,
                                            input kli_state_t   st);
      logic [7:0] word;
      word = st.rdata;
      case (sel)
         KLI_SEL_LEVEL: begin
            word = st.key_level_select;
         end
         KLI_SEL_ENBL: begin
            word = st.key_line_enable;
         end
         KLI_SEL_FLAGS: begin
            word = st.key_hit_flags;
         end
         default: begin
            word = st.rdata;
         end
      endcase
      return word;
   endfunction : read_word

   // a clear and a detection in one cycle: the detection wins, no key is lost
   function automatic logic [7:0] next_flags(input logic [7:0] flags,
                                             input logic       clr,
                                             input logic [7:0] hit);
      logic [7:0] kept;
      kept = clr ? KLI_RST_HIT_FLAGS : flags;
      return kept | hit;
   endfunction : next_flags

   // masking uses the registered flags so the request follows the flag
   function automatic logic gated_req(input logic [7:0] flags,
                                      input logic [7:0] enable,
                                      input logic       global_en);
      logic [7:0] live;
      logic       any_live;
      live     = flags & enable;
      any_live = |live;
      return any_live && global_en;
   endfunction : gated_req

   // pin to request takes two synchroniser edges, one flag edge and one
   // request edge; a pulse shorter than one clock may be missed, which is
   // far below the bounce time of a key
   kli_line_detect i_kli_line_detect (
      .sys_clk       (sys_clk),
      .rst           (rst),
      .port_one_pins (port_one_pins),
      .lines         (lines.det)
   );

   assign lines.level_sel = st_ff.key_level_select;

   // decoded strobes
   kli_reg_sel_t sel;
   logic         wr_any;
   logic         rd_map;
   logic         rd_flg;

   always_comb begin
      sel    = reg_decode(sfr_addr);
      wr_any = sfr_wr && is_mapped(sel);
      rd_map = sfr_rd && is_mapped(sel);
      rd_flg = sfr_rd && (sel == KLI_SEL_FLAGS);

      nxt_st     = st_ff;
      nxt_st.ack = 1'b0;

      // writes land at the edge that takes the strobe
      if (wr_any) begin
         nxt_st = write_reg(nxt_st, sel, sfr_wdata);
      end

      // reads answer one cycle later and see the value before any write
      if (rd_map) begin
         nxt_st.rdata = read_word(sel, st_ff);
         nxt_st.ack   = 1'b1;
      end else begin
         // an unmapped read keeps the last word and gives no ack
         nxt_st.rdata = st_ff.rdata;
      end

      // a line still at its level sets its flag again at once
      nxt_st.key_hit_flags = next_flags(st_ff.key_hit_flags, rd_flg,
                                        lines.hit);

      nxt_st.irq  = gated_req(st_ff.key_hit_flags, st_ff.key_line_enable,
                              keypad_global_irq_enable);
      // wake follows the gated request so a masked key never wakes the core
      nxt_st.wake = gated_req(st_ff.key_hit_flags, st_ff.key_line_enable,
                              keypad_global_irq_enable);
   end

   // all three registers clear together, so every line starts as plain I/O
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_ff.key_level_select <= KLI_RST_LEVEL_SEL;
         st_ff.key_line_enable  <= KLI_RST_LINE_EN;
         st_ff.key_hit_flags    <= KLI_RST_HIT_FLAGS;
         st_ff.rdata            <= KLI_RST_RDATA;
         st_ff.ack              <= 1'b0;
         st_ff.irq              <= 1'b0;
         st_ff.wake             <= 1'b0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // each output is a field of the state flop, never a gate
   assign sfr_rdata       = st_ff.rdata;
   assign sfr_ack         = st_ff.ack;
   assign key_line_enable = st_ff.key_line_enable;
   assign key_irq         = st_ff.irq;
   assign wake_req        = st_ff.wake;

endmodule : kli_top

/* common/kli_pkg.sv */
/*
 * Constants and state types for the eight-line keyboard level interrupt unit.
 * Assumes an 8-bit special function register port and a single core clock.
 */
package kli_pkg;

   localparam int unsigned KLI_LINES = 8;

   // special function register addresses
   localparam logic [7:0] KLI_ADDR_LEVEL_SEL = 8'h9c;
   localparam logic [7:0] KLI_ADDR_LINE_EN   = 8'h9d;
   localparam logic [7:0] KLI_ADDR_HIT_FLAGS = 8'h9e;

   // reset values
   localparam logic [7:0] KLI_RST_LEVEL_SEL  = 8'h00;
   localparam logic [7:0] KLI_RST_LINE_EN    = 8'h00;
   localparam logic [7:0] KLI_RST_HIT_FLAGS  = 8'h00;
   localparam logic [7:0] KLI_RST_RDATA      = 8'h00;
   // pulled-up idle level of the pins, so leaving reset shows no false hit
   localparam logic [7:0] KLI_RST_PINS       = 8'hff;

   // level select encoding per line
   localparam logic       KLI_SEL_LOW        = 1'b0;
   localparam logic       KLI_SEL_HIGH       = 1'b1;

   // stages of the pin synchroniser
   localparam int unsigned KLI_SYNC_STAGES = 2;

   typedef struct packed {
      logic [7:0] key_level_select;
      logic [7:0] key_line_enable;
      logic [7:0] key_hit_flags;
      logic [7:0] rdata;
      logic       ack;
      logic       irq;
      logic       wake;
   } kli_state_t;

   typedef struct packed {
      logic [7:0] sync1;
      logic [7:0] sync2;
   } kli_sync_t;

endpackage : kli_pkg

/* common/kli_line_if.sv */
/*
 * Carrier between the register core and the per-line level detector.
 * Assumes both ends run on the same core clock.
 */
`timescale 1ns/1ps
interface kli_line_if;
   logic [7:0] level_sel;
   logic [7:0] hit;

   modport det (
      input  level_sel,
      output hit
   );

   modport ctl (
      output level_sel,
      input  hit
   );
endinterface : kli_line_if

/* rtl/kli_line_detect.sv */
/*
 * Synchronises the eight port one pins and compares each line with its
 * selected level. Assumes the pins are asynchronous to sys_clk.
 */
`timescale 1ns/1ps
module kli_line_detect (
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic [7:0] port_one_pins,
   kli_line_if.det         lines
);
   import kli_pkg::*;

   kli_sync_t st_ff;
   kli_sync_t nxt_st;

   always_comb begin
      nxt_st       = st_ff;
      nxt_st.sync1 = port_one_pins;
      nxt_st.sync2 = st_ff.sync1;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_ff.sync1 <= KLI_RST_PINS;
         st_ff.sync2 <= KLI_RST_PINS;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // a line hits when the synchronised level equals the selected one
   assign lines.hit = ~(st_ff.sync2 ^ lines.level_sel);

endmodule : kli_line_detect

/* test/kli_keys.sv */
/* key matrix model on the port one pins.
   assumes pulled-up lines that a pressed key pulls low */
`timescale 1ns/1ps
module kli_keys (
   input  wire logic [7:0] key_down,
   output logic      [7:0] port_one_pins
);
   // lines are independent, so any subset can be wired to keys
   assign port_one_pins = ~key_down;
endmodule : kli_keys

/* test/kli_monitor.sv */
/* port checks for the keyboard interrupt unit.
   assumes one clock domain; bound to the top module at the foot */
`timescale 1ns/1ps
module kli_monitor (
   input wire logic       sys_clk,
   input wire logic       rst,
   input wire logic [7:0] sfr_addr,
   input wire logic       sfr_wr,
   input wire logic       sfr_rd,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   input wire logic       sfr_ack,
   input wire logic       keypad_global_irq_enable,
   input wire logic [7:0] key_line_enable,
   input wire logic       key_irq,
   input wire logic       wake_req
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   sequence s_disarm;
      !keypad_global_irq_enable ##1 1'b1;
   endsequence
   a_wake_tracks_irq: assert property (wake_req == key_irq) else $error("wake");
   a_global_gates: assert property (s_disarm |-> !key_irq) else $error("global");
   a_irq_cause: assert property ($rose(key_irq) |-> $past(key_line_enable) != 8'h00)
      else $error("irq cause");
   a_enable_write: assert property (sfr_wr && sfr_addr == 8'h9d
      |=> key_line_enable == $past(sfr_wdata)) else $error("enable write");
   a_enable_cause: assert property (!$stable(key_line_enable) |-> $past(sfr_wr))
      else $error("enable cause");
   a_mapped_ack: assert property (sfr_rd && sfr_addr inside {[8'h9c:8'h9e]} |=> sfr_ack)
      else $error("ack");
   a_unmapped_quiet: assert property (sfr_rd && !(sfr_addr inside {[8'h9c:8'h9e]})
      |=> !sfr_ack) else $error("unmapped");
   a_rdata_holds: assert property (sfr_rdata != $past(sfr_rdata) |-> $past(sfr_rd))
      else $error("rdata");
endmodule : kli_monitor

bind kli_top kli_monitor i_kli_monitor (.sys_clk, .rst, .sfr_addr, .sfr_wr, .sfr_rd,
   .sfr_wdata, .sfr_rdata, .sfr_ack, .keypad_global_irq_enable, .key_line_enable, .key_irq,
   .wake_req);

/* test/tb_kli_top.sv */
/* self-checking bench for the keyboard interrupt unit.
   assumes the key model and the bound port monitor */
`timescale 1ns/1ps
module tb_kli_top;
   import kli_pkg::*;
   logic       sys_clk, rst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0, sfr_ack, key_irq, wake_req;
   logic       keypad_global_irq_enable = 1'b0;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, key_down = 8'h00;
   logic [7:0] sfr_rdata, key_line_enable, port_one_pins;
   int         fail_count = 0, checked = 0;
   kli_top i_kli_top (.sys_clk, .rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
      .sfr_ack, .port_one_pins, .keypad_global_irq_enable, .key_line_enable, .key_irq,
      .wake_req);
   kli_keys i_kli_keys (.key_down, .port_one_pins);
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   task chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      {sfr_addr, sfr_wdata, sfr_wr} <= {a, d, 1'b1};
      @(posedge sys_clk);
      sfr_wr <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] a, input logic [7:0] e, input logic ack);
      @(posedge sys_clk);
      {sfr_addr, sfr_rd} <= {a, 1'b1};
      @(posedge sys_clk);
      sfr_rd <= 1'b0;
      #1;
      chk("ack", {7'h0, ack}, {7'h0, sfr_ack});
      chk("rdata", e, sfr_rdata);
   endtask : rd
   task irq_after(input int n, input logic e);
      repeat (n) @(posedge sys_clk);
      #1;
      chk("key_irq", {7'h0, e}, {7'h0, key_irq});
      chk("wake_req", {7'h0, e}, {7'h0, wake_req});
   endtask : irq_after
   task test_done;
      $display("checked %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : test_done
   initial begin
      #50000;
      fail_count++;
      test_done();
   end
   initial begin
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      rd(KLI_ADDR_LEVEL_SEL, 8'h00, 1'b1);
      rd(KLI_ADDR_LINE_EN, 8'h00, 1'b1);
      rd(KLI_ADDR_HIT_FLAGS, 8'h00, 1'b1);
      $display("test reset done");
      // released lines sit high, so only high-select lines match
      wr(KLI_ADDR_LEVEL_SEL, 8'ha5);
      irq_after(3, 1'b0);
      rd(KLI_ADDR_HIT_FLAGS, 8'ha5, 1'b1);
      rd(KLI_ADDR_HIT_FLAGS, 8'ha5, 1'b1);
      wr(KLI_ADDR_LEVEL_SEL, 8'h00);
      wr(KLI_ADDR_HIT_FLAGS, 8'hff);
      rd(KLI_ADDR_HIT_FLAGS, 8'ha5, 1'b1);
      // an unmapped read keeps the word just read
      rd(8'h9f, 8'ha5, 1'b0);
      rd(KLI_ADDR_HIT_FLAGS, 8'h00, 1'b1);
      $display("test registers done");
      wr(KLI_ADDR_LINE_EN, 8'h01);
      keypad_global_irq_enable <= 1'b1;
      key_down <= 8'h03;
      irq_after(5, 1'b1);
      chk("line_enable", 8'h01, key_line_enable);
      @(posedge sys_clk);
      keypad_global_irq_enable <= 1'b0;
      irq_after(2, 1'b0);
      @(posedge sys_clk);
      keypad_global_irq_enable <= 1'b1;
      key_down <= 8'h00;
      irq_after(2, 1'b1);
      rd(KLI_ADDR_HIT_FLAGS, 8'h03, 1'b1);
      irq_after(2, 1'b0);
      $display("test interrupt done");
      test_done();
   end
endmodule : tb_kli_top
